// [cra_defs.vh]
// Constants for the register access attribute bank.
// Assumes inclusion by cra_regbank.v, cra_axil.v, the monitor and the bench.
`ifndef CRA_DEFS_VH
`define CRA_DEFS_VH
`define CRA_OFF_SEL 8'h00
`define CRA_OFF_CTRL 8'h04
`define CRA_OFF_STAT 8'h08
`define CRA_OFF_SET 8'h0C
`define CRA_OFF_LOCK 8'h10
`define CRA_OFF_ONCE 8'h14
`define CRA_OFF_STRAP 8'h18
`define CRA_OFF_ERRLOG 8'h1C
`define CRA_OFF_ERRCMD 8'h20
`define CRA_OFF_CMD 8'h24
`define CRA_OFF_IMASK 8'h28
`define CRA_OFF_ISTAT 8'h2C
`define CRA_CTRL_RST 32'h0000_0000
`define CRA_SEL_RST 32'h0000_0000
`define CRA_ZERO 32'h0000_0000
`define CRA_RESV_RD 32'h0000_0000
`define CRA_CTRL_LOCKEN 0
`define CRA_STB_ALL 4'hF
`define CRA_RESP_OKAY 2'b00
`define CRA_RESP_SLVERR 2'b10
`define CRA_IRQ_W 3
`define CRA_IRQ_ERR 0
`define CRA_IRQ_CMD 1
`define CRA_IRQ_SELERR 2
`endif

// [cra_axil.v]
// AXI4-Lite write and read front end; one transfer of each kind at a time.
// Assumes a master on sys_clk obeying AXI4-Lite handshakes.
`timescale 1ns/1ps
`include "cra_defs.vh"
module cra_axil #(
    parameter AW = 8
) (
    input  wire          sys_clk, // Clock
    input  wire          rst_b,   // Async reset, low
    input  wire          clk_en,  // Freeze when low
    input  wire [AW-1:0] awaddr,  // Write address
    input  wire          awvalid, // Write address valid
    output reg           awready, // Write address ready
    input  wire [31:0]   wdata,   // Write data
    input  wire [3:0]    wstrb,   // Byte enables
    input  wire          wvalid,  // Write data valid
    output reg           wready,  // Write data ready
    output reg  [1:0]    bresp,   // Write response
    output reg           bvalid,  // Write response valid
    input  wire          bready,  // Write response ready
    input  wire [AW-1:0] araddr,  // Read address
    input  wire          arvalid, // Read address valid
    output reg           arready, // Read address ready
    output reg  [31:0]   rdata,   // Read data
    output reg  [1:0]    rresp,   // Read response
    output reg           rvalid,  // Read valid
    input  wire          rready,  // Read ready
    output reg           wr_go,   // One-cycle write strobe
    output reg  [AW-1:0] wr_addr, // Write byte address
    output reg  [31:0]   wr_data, // Write data
    output reg  [3:0]    wr_strb, // Write lanes
    input  wire          wr_err,  // Write refused
    output reg           rd_go,   // One-cycle read strobe
    output reg  [AW-1:0] rd_addr, // Read address
    input  wire [31:0]   rd_data, // Read data, same cycle
    input  wire          rd_err   // Read refused
);
    reg aw_have;
    reg w_have;
    reg b_pend;
    reg r_pend;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            arready <= 1'b0;
            bvalid  <= 1'b0;
            rvalid  <= 1'b0;
            bresp   <= `CRA_RESP_OKAY;
            rresp   <= `CRA_RESP_OKAY;
            rdata   <= `CRA_ZERO;
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            b_pend  <= 1'b0;
            r_pend  <= 1'b0;
            wr_go   <= 1'b0;
            rd_go   <= 1'b0;
            wr_addr <= {AW{1'b0}};
            rd_addr <= {AW{1'b0}};
            wr_data <= `CRA_ZERO;
            wr_strb <= 4'h0;
        end else if (clk_en) begin
            wr_go   <= 1'b0;
            rd_go   <= 1'b0;
            awready <= !aw_have && !bvalid && !b_pend && !awready;
            wready  <= !w_have && !bvalid && !b_pend && !wready;
            arready <= !r_pend && !rvalid && !arready;
            // Address and data may arrive in either order
            if (awvalid && awready) begin
                aw_have <= 1'b1;
                wr_addr <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have  <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
                wready  <= 1'b0;
            end
            if (aw_have && w_have && !b_pend) begin
                wr_go   <= 1'b1;
                b_pend  <= 1'b1;
                aw_have <= 1'b0;
                w_have  <= 1'b0;
            end
            // Error flag is valid with the strobe
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_err ? `CRA_RESP_SLVERR : `CRA_RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                b_pend <= 1'b0;
            end
            if (arvalid && arready) begin
                rd_addr <= araddr;
                rd_go   <= 1'b1;
                r_pend  <= 1'b1;
                arready <= 1'b0;
            end
            if (rd_go) begin
                rvalid <= 1'b1;
                rdata  <= rd_data;
                rresp  <= rd_err ? `CRA_RESP_SLVERR : `CRA_RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                r_pend <= 1'b0;
            end
        end
    end
endmodule // cra_axil

// [cra_regbank.v]
// Register bank showing each access attribute over AXI4-Lite.
// Assumes strap and event inputs come from pins; both resets are async low.
// Summary of operation
// RULE1: Byte, word, dword writes touch addressed lanes; IMASK and ISTAT writes ignore the lanes
// RULE2: Selector register takes only full dword access
// RULE3: Lowest byte lane holds least significant byte
// RULE4: Writes to read-only bits are ignored
// RULE5: Write-only writes fire a pulse; reads zero
// RULE6: Clear-on-one bits set only by hardware
// RULE7: Set-on-one bits cleared only by hardware
// RULE8: Lockable bits freeze while lock asserted
// RULE9: Write-once bits take first write only
// RULE10: Software avoids writing reserved registers
// RULE11: Software merges reserved bits, except selector
// RULE12: Reset loads defaults, some from straps
// RULE13: Sticky registers survive hard reset only
// RULE14: Error log sticky; error command not sticky
// RULE15: Software programs registers after bring-up
// RULE16: Every register reachable through host access
// RULE17: Hard reset clears all but sticky bits
// RULE18: Power-good reset clears everything; here it leaves the AXI front end and the event, clear, status and lock synchronisers to hard reset
// RULE19: Hardware set beats software clear
`timescale 1ns/1ps
`include "cra_defs.vh"
module cra_regbank #(
    parameter AW = 8,
    parameter DW = 32
) (
    input  wire          sys_clk,    // Clock, 125 MHz
    input  wire          rst_b,      // Hard reset, async, low
    input  wire          power_good_reset_b, // Power-good reset, async, low
    input  wire          clk_en,     // Freeze when low
    input  wire [AW-1:0] s_awaddr,   // AXI write address
    input  wire          s_awvalid,  // AXI write address valid
    output wire          s_awready,  // AXI write address ready
    input  wire [31:0]   s_wdata,    // AXI write data
    input  wire [3:0]    s_wstrb,    // AXI byte enables
    input  wire          s_wvalid,   // AXI write data valid
    output wire          s_wready,   // AXI write data ready
    output wire [1:0]    s_bresp,    // AXI write response
    output wire          s_bvalid,   // AXI write response valid
    input  wire          s_bready,   // AXI write response ready
    input  wire [AW-1:0] s_araddr,   // AXI read address
    input  wire          s_arvalid,  // AXI read address valid
    output wire          s_arready,  // AXI read address ready
    output wire [31:0]   s_rdata,    // AXI read data
    output wire [1:0]    s_rresp,    // AXI read response
    output wire          s_rvalid,   // AXI read valid
    input  wire          s_rready,   // AXI read ready
    input  wire [DW-1:0] strap_pins, // Strap levels
    input  wire [DW-1:0] hw_event,   // Async events to clear-on-one bits
    input  wire [DW-1:0] hw_clear,   // Async clears of set-on-one bits
    input  wire          hw_lock,    // Async lock for lockable bits
    input  wire [DW-1:0] hw_status,  // Async read-only status
    output reg  [DW-1:0] cmd_pulse,  // Write-only action pulses
    output reg  [DW-1:0] ctrl_out,   // Lockable control bits
    output reg  [DW-1:0] once_out,   // Write-once bits
    output reg  [DW-1:0] set_out,    // Set-on-one bits
    output reg           irq         // Level interrupt
);
    wire          wr_go;
    wire [AW-1:0] wr_addr;
    wire [31:0]   wr_data;
    wire [3:0]    wr_strb;
    wire          rd_go;
    wire [AW-1:0] rd_addr;
    reg  [31:0]   rd_data;
    reg           rd_err;
    reg           wr_err;

    cra_axil #(.AW(AW)) u_axil (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .awaddr  (s_awaddr),
        .awvalid (s_awvalid),
        .awready (s_awready),
        .wdata   (s_wdata),
        .wstrb   (s_wstrb),
        .wvalid  (s_wvalid),
        .wready  (s_wready),
        .bresp   (s_bresp),
        .bvalid  (s_bvalid),
        .bready  (s_bready),
        .araddr  (s_araddr),
        .arvalid (s_arvalid),
        .arready (s_arready),
        .rdata   (s_rdata),
        .rresp   (s_rresp),
        .rvalid  (s_rvalid),
        .rready  (s_rready),
        .wr_go   (wr_go),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_go   (rd_go),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // Expand byte enables to a bit mask; lane 0 is the low byte
    function [31:0] lane_mask;
        input [3:0] s;
        integer k;
        begin
            lane_mask = `CRA_ZERO;
            for (k = 0; k < 4; k = k + 1) begin
                lane_mask[k*8 +: 8] = {8{s[k]}};
            end
        end
    endfunction

    function hit;
        input [AW-1:0] a;
        input [7:0]    off;
        begin
            hit = (a[7:2] == off[7:2]);
        end
    endfunction

    // Two-stage synchronisers for every pin input
    reg [DW-1:0] ev_s1, ev_s2, clr_s1, clr_s2, st_s1, st_s2, strap_s1, strap_s2;
    reg          lk_s1, lk_s2;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_s1    <= {DW{1'b0}};
            ev_s2    <= {DW{1'b0}};
            clr_s1   <= {DW{1'b0}};
            clr_s2   <= {DW{1'b0}};
            st_s1    <= {DW{1'b0}};
            st_s2    <= {DW{1'b0}};
            lk_s1    <= 1'b0;
            lk_s2    <= 1'b0;
        end else if (clk_en) begin
            ev_s1    <= hw_event;
            ev_s2    <= ev_s1;
            clr_s1   <= hw_clear;
            clr_s2   <= clr_s1;
            st_s1    <= hw_status;
            st_s2    <= st_s1;
            lk_s1    <= hw_lock;
            lk_s2    <= lk_s1;
        end
    end

    // No reset: the pins are through both stages by release
    always @(posedge sys_clk) begin
        if (clk_en) begin
            strap_s1 <= strap_pins;
            strap_s2 <= strap_s1;
        end
    end

    reg [DW-1:0] ev_d;
    wire [DW-1:0] ev_rise = ev_s2 & ~ev_d;

    wire [31:0] wmask = lane_mask(wr_strb);                 // [RULE1] [RULE3]
    wire        full  = (wr_strb == `CRA_STB_ALL);

    reg [31:0]   sel_reg;
    reg [DW-1:0] stat_reg;
    reg [DW-1:0] strap_reg;
    reg [DW-1:0] errcmd_reg;
    reg [DW-1:0] once_done;
    reg [`CRA_IRQ_W-1:0] imask;
    reg [`CRA_IRQ_W-1:0] istat;
    reg          strap_take;
    reg [DW-1:0] errlog_reg;

    wire lock_now = lk_s2 | ctrl_out[`CRA_CTRL_LOCKEN];
    wire sel_bad  = wr_go && hit(wr_addr, `CRA_OFF_SEL) && !full;

    always @* begin
        wr_err = sel_bad;                                   // [RULE2]
    end

    wire [`CRA_IRQ_W-1:0] ev_irq;
    assign ev_irq[`CRA_IRQ_ERR]    = |ev_rise;
    assign ev_irq[`CRA_IRQ_CMD]    = wr_go && hit(wr_addr, `CRA_OFF_CMD);
    assign ev_irq[`CRA_IRQ_SELERR] = sel_bad;

    // Non-sticky state: cleared by either reset
    wire rst_any_b = rst_b & power_good_reset_b;            // [RULE17] [RULE18]
    genvar g;
    always @(posedge sys_clk or negedge rst_any_b) begin
        if (!rst_any_b) begin                               // [RULE12]
            sel_reg    <= `CRA_SEL_RST;
            ctrl_out   <= `CRA_CTRL_RST;
            set_out    <= {DW{1'b0}};
            once_out   <= {DW{1'b0}};
            once_done  <= {DW{1'b0}};
            errcmd_reg <= {DW{1'b0}};                       // [RULE14]
            cmd_pulse  <= {DW{1'b0}};
            strap_reg  <= {DW{1'b0}};
            strap_take <= 1'b1;
            imask      <= {`CRA_IRQ_W{1'b0}};
            istat      <= {`CRA_IRQ_W{1'b0}};
            irq        <= 1'b0;
            stat_reg   <= {DW{1'b0}};
            ev_d       <= {DW{1'b0}};
        end else if (clk_en) begin
            ev_d       <= ev_s2;
            stat_reg   <= st_s2;                            // [RULE4]
            cmd_pulse  <= {DW{1'b0}};
            strap_take <= 1'b0;
            if (strap_take) begin
                strap_reg <= strap_s2;                      // [RULE12]
            end
            if (wr_go && hit(wr_addr, `CRA_OFF_SEL) && full) begin
                sel_reg <= wr_data;                         // [RULE2]
            end
            if (wr_go && hit(wr_addr, `CRA_OFF_CTRL) && !lock_now) begin
                ctrl_out <= (ctrl_out & ~wmask) | (wr_data & wmask); // [RULE8]
            end
            if (wr_go && hit(wr_addr, `CRA_OFF_CMD)) begin
                cmd_pulse <= wr_data & wmask;               // [RULE5]
            end
            if (wr_go && hit(wr_addr, `CRA_OFF_ERRCMD)) begin
                errcmd_reg <= (errcmd_reg & ~wmask) | (wr_data & wmask);
            end
            // Hardware clear beats a same-cycle set
            set_out <= (set_out | ((wr_go && hit(wr_addr, `CRA_OFF_SET)) ?
                       (wr_data & wmask) : {DW{1'b0}})) & ~clr_s2;  // [RULE7]
            if (wr_go && hit(wr_addr, `CRA_OFF_ONCE)) begin
                // Per-lane lock: the first write to a lane sticks
                once_out  <= (once_out & (once_done | ~wmask)) |
                             (wr_data & wmask & ~once_done); // [RULE9]
                once_done <= once_done | wmask;
            end
            if (wr_go && hit(wr_addr, `CRA_OFF_IMASK)) begin
                imask <= wr_data[`CRA_IRQ_W-1:0];
            end
            istat <= (istat & ~((wr_go && hit(wr_addr, `CRA_OFF_ISTAT)) ?
                     wr_data[`CRA_IRQ_W-1:0] : {`CRA_IRQ_W{1'b0}})) | ev_irq; // [RULE19]
            irq   <= |(istat & imask);
        end
    end

    // Sticky error log: of the two resets, only power-good clears it
    generate
        for (g = 0; g < DW; g = g + 1) begin : g_log
            always @(posedge sys_clk or negedge power_good_reset_b) begin
                if (!power_good_reset_b) begin              // [RULE13] [RULE14]
                    errlog_reg[g] <= 1'b0;
                end else if (clk_en) begin
                    // Set wins over a same-cycle clear write
                    if (ev_rise[g]) begin
                        errlog_reg[g] <= 1'b1;              // [RULE6] [RULE19]
                    end else if (rst_b && wr_go && hit(wr_addr, `CRA_OFF_ERRLOG) &&
                                 wmask[g] && wr_data[g]) begin
                        errlog_reg[g] <= 1'b0;              // [RULE6]
                    end
                end
            end
        end
    endgenerate

    always @* begin
        rd_err  = 1'b0;
        rd_data = `CRA_RESV_RD;
        if (hit(rd_addr, `CRA_OFF_SEL)) rd_data = sel_reg;  // [RULE16]
        else if (hit(rd_addr, `CRA_OFF_CTRL))   rd_data = ctrl_out;
        else if (hit(rd_addr, `CRA_OFF_STAT))   rd_data = stat_reg;
        else if (hit(rd_addr, `CRA_OFF_SET))    rd_data = set_out;
        else if (hit(rd_addr, `CRA_OFF_LOCK))   rd_data = {{(DW-1){1'b0}}, lock_now};
        else if (hit(rd_addr, `CRA_OFF_ONCE))   rd_data = once_out;
        else if (hit(rd_addr, `CRA_OFF_STRAP))  rd_data = strap_reg;
        else if (hit(rd_addr, `CRA_OFF_ERRLOG)) rd_data = errlog_reg;
        else if (hit(rd_addr, `CRA_OFF_ERRCMD)) rd_data = errcmd_reg;
        else if (hit(rd_addr, `CRA_OFF_CMD))    rd_data = `CRA_ZERO; // [RULE5]
        else if (hit(rd_addr, `CRA_OFF_IMASK))  rd_data = {{(DW-`CRA_IRQ_W){1'b0}}, imask};
        else if (hit(rd_addr, `CRA_OFF_ISTAT))  rd_data = {{(DW-`CRA_IRQ_W){1'b0}}, istat};
        else rd_err = 1'b1;
    end
endmodule // cra_regbank

// [cra_host.sv]
// Host model: AXI4-Lite master, one write and one read at a time.
// Assumes a slave on sys_clk that keeps the AXI4-Lite handshakes.
`timescale 1ns/1ps
module cra_host (
    input  wire        sys_clk, // Clock
    output reg  [7:0]  awaddr, araddr, // Write and read address
    output reg  [31:0] wdata, // Write data
    output reg  [3:0]  wstrb, // Byte lanes
    output reg         awvalid, wvalid, arvalid, // Request valids
    output reg         bready, rready, // Response readys
    input  wire        awready, wready, arready, // Request readys
    input  wire        bvalid, rvalid, // Response valids
    input  wire [1:0]  bresp, rresp, // Response codes
    input  wire [31:0] rdata // Read data
);
    initial {awaddr, araddr, wdata, wstrb, awvalid, wvalid, arvalid, bready, rready} = '0;
    // Released payload turns to its inverse so a late capture shows up
    // Callers write only mapped places, some with narrow byte lanes
    task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
        reg aw_ok, w_ok;
        begin
            aw_ok = 1'b0;
            w_ok = 1'b0;
            @(posedge sys_clk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!(aw_ok && w_ok)) begin
                @(posedge sys_clk);
                if (awvalid && awready) begin
                    aw_ok = 1'b1;
                    awvalid <= 1'b0;
                    awaddr <= ~a;
                end
                if (wvalid && wready) begin
                    w_ok = 1'b1;
                    wvalid <= 1'b0;
                    wdata <= ~d;
                end
            end
            while (!bvalid) @(posedge sys_clk);
            r = bresp;
            bready <= 1'b0;
        end
    endtask
    task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge sys_clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            @(posedge sys_clk);
            while (!arready) @(posedge sys_clk);
            arvalid <= 1'b0;
            araddr <= ~a;
            while (!rvalid) @(posedge sys_clk);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
        end
    endtask
endmodule // cra_host

// [cra_regbank_monitor.sv]
// Port checks for the register bank, attached by the bind at the foot.
// Assumes one clock and two async low resets.
`timescale 1ns/1ps
`include "cra_defs.vh"
module cra_regbank_monitor #(
    parameter AW = 8,
    parameter DW = 32
) (
    input wire          sys_clk, rst_b, power_good_reset_b, // Clock and resets
    input wire [AW-1:0] s_awaddr, s_araddr, // Addresses
    input wire          s_awvalid, s_awready, s_wvalid, s_wready, // Write requests
    input wire [3:0]    s_wstrb, // Byte lanes
    input wire [1:0]    s_bresp, s_rresp, // Responses
    input wire          s_bvalid, s_bready, s_rvalid, // Response handshakes
    input wire          s_arvalid, s_arready, // Read request
    input wire [31:0]   s_rdata, // Read data
    input wire [DW-1:0] cmd_pulse, ctrl_out, once_out, set_out, // Attribute outputs
    input wire          irq // Interrupt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b || !power_good_reset_b);
    wire wr_take = s_awvalid && s_awready && s_wvalid && s_wready;
    wire rd_take = s_arvalid && s_arready;

    a_write_answer: assert property (wr_take |-> ##[1:3] s_bvalid)
        else $error("write response late");
    a_read_answer: assert property (rd_take |-> ##[1:3] s_rvalid)
        else $error("read response late");
    a_bvalid_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
    a_sel_dword: assert property (
        wr_take && s_awaddr == `CRA_OFF_SEL && s_wstrb != `CRA_STB_ALL
        |-> ##[1:3] (s_bvalid && s_bresp == `CRA_RESP_SLVERR))
        else $error("narrow selector write not refused");
    a_unmap_read: assert property (
        rd_take && s_araddr > `CRA_OFF_ISTAT + 3
        |-> ##[1:3] (s_rvalid && s_rresp == `CRA_RESP_SLVERR && s_rdata == 32'h0000_0000))
        else $error("unmapped read not refused");
    a_cmd_single: assert property (cmd_pulse != 0 |=> cmd_pulse == 0)
        else $error("action pulse longer than one cycle");
    a_ctrl_frozen: assert property (ctrl_out[`CRA_CTRL_LOCKEN] |=> $stable(ctrl_out))
        else $error("locked control changed");
    a_reset_quiet: assert property (disable iff (!power_good_reset_b)
        !rst_b |-> (ctrl_out == 0 && once_out == 0 && set_out == 0 && cmd_pulse == 0 && !irq))
        else $error("state not cleared in hard reset");

    c_sel_refused: cover property (s_bvalid && s_bresp == `CRA_RESP_SLVERR);
    c_irq_rise: cover property ($rose(irq));
    c_cmd_fire: cover property (cmd_pulse != 0);
endmodule // cra_regbank_monitor

bind cra_regbank cra_regbank_monitor #(.AW(AW), .DW(DW)) i_cra_regbank_monitor (
    .sys_clk, .rst_b, .power_good_reset_b, .s_awaddr, .s_araddr, .s_awvalid, .s_awready,
    .s_wvalid, .s_wready, .s_wstrb, .s_bresp, .s_rresp, .s_bvalid, .s_bready, .s_rvalid,
    .s_arvalid, .s_arready, .s_rdata, .cmd_pulse, .ctrl_out, .once_out, .set_out, .irq);

// [cra_regbank_bench.sv]
// Bench for the register bank: bus tasks, attribute and reset sequences.
// Assumes cra_host as bus master and the monitor bound to the bank.
`timescale 1ns/1ps
`include "cra_defs.vh"
module cra_regbank_bench;
    localparam [31:0] STRAP_V = 32'h5A00_00C3;
    localparam [31:0] STAT_V  = 32'h0000_9E17;
    localparam [1:0]  OK      = `CRA_RESP_OKAY;
    localparam [1:0]  ERR     = `CRA_RESP_SLVERR;
    reg          sys_clk = 1'b0;
    reg          rst_b = 1'b0, power_good_reset_b = 1'b0, hw_lock = 1'b0;
    reg  [31:0]  hw_event = 32'h0000_0000, hw_clear = 32'h0000_0000, pulse_seen = 32'h0000_0000;
    wire [7:0]   s_awaddr, s_araddr;
    wire [31:0]  s_wdata, s_rdata, cmd_pulse, ctrl_out, once_out, set_out;
    wire [3:0]   s_wstrb;
    wire [1:0]   s_bresp, s_rresp;
    wire         s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    wire         s_arvalid, s_arready, s_rvalid, s_rready, irq;
    integer      err_count = 0, check_count = 0, cycles = 0;

    cra_regbank i_cra_regbank (
        .sys_clk, .rst_b, .power_good_reset_b, .clk_en(1'b1), .s_awaddr, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
        .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
        .strap_pins(STRAP_V), .hw_event, .hw_clear, .hw_lock, .hw_status(STAT_V),
        .cmd_pulse, .ctrl_out, .once_out, .set_out, .irq);
    cra_host i_cra_host (
        .sys_clk, .awaddr(s_awaddr), .araddr(s_araddr), .wdata(s_wdata), .wstrb(s_wstrb),
        .awvalid(s_awvalid), .wvalid(s_wvalid), .arvalid(s_arvalid), .bready(s_bready),
        .rready(s_rready), .awready(s_awready), .wready(s_wready), .arready(s_arready),
        .bvalid(s_bvalid), .rvalid(s_rvalid), .bresp(s_bresp), .rresp(s_rresp), .rdata(s_rdata));

    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cmd_pulse !== 32'h0000_0000) pulse_seen <= cmd_pulse;
        if (cycles == 6000) begin
            err_count = err_count + 1;
            wrap_up;
        end
    end

    task wrap_up;
        begin
            $display("checks %0d, mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task automatic chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0t: saw %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        reg [1:0] r;
        begin
            i_cra_host.wr(a, d, s, r);
            chk(32'(r), 32'(er));
        end
    endtask
    task automatic rd(input [7:0] a, input [31:0] e, input [1:0] er);
        reg [31:0] d;
        reg [1:0]  r;
        begin
            i_cra_host.rd(a, d, r);
            chk(d, e);
            chk(32'(r), 32'(er));
        end
    endtask
    // Events pass a synchroniser: wait on a bound, not a fixed count
    task automatic irq_is(input l);
        integer n;
        begin
            for (n = 0; n < 16 && irq !== l; n = n + 1) @(posedge sys_clk);
            chk(32'(irq), 32'(l));
        end
    endtask
    task automatic resets(input pg);
        begin
            @(posedge sys_clk);
            rst_b <= 1'b0;
            power_good_reset_b <= ~pg;
            repeat (4) @(posedge sys_clk);
            rst_b <= 1'b1;
            power_good_reset_b <= 1'b1;
        end
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        power_good_reset_b <= 1'b1;
        rd(`CRA_OFF_CTRL, `CRA_CTRL_RST, OK);
        rd(`CRA_OFF_SEL, `CRA_SEL_RST, OK);
        rd(`CRA_OFF_STRAP, STRAP_V, OK);
        wr(`CRA_OFF_ERRCMD, 32'h1122_3344, 4'hF, OK);
        wr(`CRA_OFF_ERRCMD, 32'hFFFF_FF77, 4'h1, OK);
        wr(`CRA_OFF_ERRCMD, 32'hBBCC_FFFF, 4'hC, OK);
        rd(`CRA_OFF_ERRCMD, 32'hBBCC_3377, OK);
        wr(`CRA_OFF_SEL, 32'h8000_0004, 4'h3, ERR);
        rd(`CRA_OFF_SEL, 32'h0000_0000, OK);
        wr(`CRA_OFF_SEL, 32'h8000_0004, 4'hF, OK);
        rd(`CRA_OFF_SEL, 32'h8000_0004, OK);
        wr(`CRA_OFF_STAT, 32'hFFFF_FFFF, 4'hF, OK);
        rd(`CRA_OFF_STAT, STAT_V, OK);
        wr(`CRA_OFF_STRAP, 32'h0000_0000, 4'hF, OK);
        rd(`CRA_OFF_STRAP, STRAP_V, OK);
        wr(`CRA_OFF_CMD, 32'hFF00_0081, 4'h1, OK);
        rd(`CRA_OFF_CMD, 32'h0000_0000, OK);
        chk(pulse_seen, 32'h0000_0081);
        wr(`CRA_OFF_IMASK, 32'h0000_0001, 4'hF, OK);
        hw_event <= 32'h0000_0008;
        irq_is(1'b1);
        hw_event <= 32'h0000_0000;
        rd(`CRA_OFF_ERRLOG, 32'h0000_0008, OK);
        wr(`CRA_OFF_ERRLOG, 32'h0000_0000, 4'hF, OK);
        rd(`CRA_OFF_ERRLOG, 32'h0000_0008, OK);
        wr(`CRA_OFF_ERRLOG, 32'h0000_0008, 4'hF, OK);
        rd(`CRA_OFF_ERRLOG, 32'h0000_0000, OK);
        rd(`CRA_OFF_ISTAT, 32'h0000_0007, OK);
        wr(`CRA_OFF_IMASK, 32'h0000_0000, 4'hF, OK);
        irq_is(1'b0);
        wr(`CRA_OFF_IMASK, 32'h0000_0001, 4'hF, OK);
        irq_is(1'b1);
        wr(`CRA_OFF_ISTAT, 32'h0000_0001, 4'hF, OK);
        irq_is(1'b0);
        rd(`CRA_OFF_ISTAT, 32'h0000_0006, OK);
        hw_event <= 32'h0000_0020;
        irq_is(1'b1);
        hw_event <= 32'h0000_0000;
        wr(`CRA_OFF_SET, 32'h0000_00F0, 4'hF, OK);
        wr(`CRA_OFF_SET, 32'h0000_0000, 4'hF, OK);
        rd(`CRA_OFF_SET, 32'h0000_00F0, OK);
        hw_clear <= 32'h0000_0010;
        repeat (5) @(posedge sys_clk);
        hw_clear <= 32'h0000_0000;
        rd(`CRA_OFF_SET, 32'h0000_00E0, OK);
        chk(set_out, 32'h0000_00E0);
        wr(`CRA_OFF_CTRL, 32'h0000_0A00, 4'hF, OK);
        hw_lock <= 1'b1;
        repeat (5) @(posedge sys_clk);
        wr(`CRA_OFF_CTRL, 32'h0000_0500, 4'hF, OK);
        rd(`CRA_OFF_CTRL, 32'h0000_0A00, OK);
        hw_lock <= 1'b0;
        repeat (5) @(posedge sys_clk);
        wr(`CRA_OFF_CTRL, 32'h0000_0A01, 4'hF, OK);
        wr(`CRA_OFF_CTRL, 32'h0000_0500, 4'hF, OK);
        rd(`CRA_OFF_CTRL, 32'h0000_0A01, OK);
        wr(`CRA_OFF_ONCE, 32'h0000_00FF, 4'h1, OK);
        wr(`CRA_OFF_ONCE, 32'h0000_3300, 4'h3, OK);
        rd(`CRA_OFF_ONCE, 32'h0000_33FF, OK);
        rd(8'h40, 32'h0000_0000, ERR);
        resets(1'b0);
        rd(`CRA_OFF_ERRLOG, 32'h0000_0020, OK);
        rd(`CRA_OFF_ERRCMD, 32'h0000_0000, OK);
        rd(`CRA_OFF_CTRL, 32'h0000_0000, OK);
        wr(`CRA_OFF_ONCE, 32'h0000_0055, 4'h1, OK);
        rd(`CRA_OFF_ONCE, 32'h0000_0055, OK);
        resets(1'b1);
        rd(`CRA_OFF_ERRLOG, 32'h0000_0000, OK);
        rd(`CRA_OFF_STRAP, STRAP_V, OK);
        wrap_up;
    end
endmodule // cra_regbank_bench
